// ==== common/rlmc_pkg.sv ====
// package for the remote/local mode control block: codes, layouts, reset values
// assumes a 200 MHz clock and a command decoder that delivers one-cycle pulses
package rlmc_pkg;
	localparam int unsigned CLOCK_KHZ = 200000;
	localparam int unsigned SETTLE_MS = 3000;
	localparam int unsigned SETTLE_CYCLES = SETTLE_MS * CLOCK_KHZ;
	localparam int unsigned TIMER_W = 30;
	localparam logic [4:0] ADDR_MAX = 5'h1e;
	localparam logic [4:0] ADDR_RESET = 5'h06;
	localparam logic [2:0] BAUD_MAX = 3'h4;
	localparam logic [2:0] BAUD_RESET = 3'h3;
	// register offsets
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	// config fields
	localparam int unsigned CFG_ADDR_LSB = 0;
	localparam int unsigned CFG_BAUD_LSB = 8;
	// status fields
	localparam int unsigned ST_MODE_LSB = 0;
	localparam int unsigned ST_RS485_BIT = 4;
	localparam int unsigned ST_AVOLT_BIT = 5;
	localparam int unsigned ST_ACURR_BIT = 6;
	localparam int unsigned ST_RESIST_BIT = 7;
	localparam int unsigned ST_MENU_BIT = 8;
	// setup switch bank bit positions (1 = up)
	localparam int unsigned SW_VOLT_REMOTE = 0;
	localparam int unsigned SW_CURR_REMOTE = 1;
	localparam int unsigned SW_PORT_TYPE = 5;
	localparam int unsigned SW_RESIST_A = 6;
	localparam int unsigned SW_RESIST_B = 7;
	localparam int unsigned SW_W = 9;

	typedef enum logic [2:0] {
		BAUD_1200 = 3'h0,
		BAUD_2400 = 3'h1,
		BAUD_4800 = 3'h2,
		BAUD_9600 = 3'h3,
		BAUD_19200 = 3'h4
	} rlmc_baud_e_t;

	typedef enum logic [2:0] {
		MODE_LOCAL = 3'b001,
		MODE_REMOTE = 3'b010,
		MODE_LOCKOUT = 3'b100
	} rlmc_mode_t;

	typedef enum logic [2:0] {
		CMD_QUERY = 3'h0,
		CMD_SAFE_RESET = 3'h1,
		CMD_VOLTAGE_PROGRAM = 3'h2,
		CMD_CURRENT_PROGRAM = 3'h3,
		CMD_OUTPUT = 3'h4,
		CMD_REMOTE_MODE = 3'h5,
		CMD_OTHER_SETTING = 3'h6
	} rlmc_cmd_kind_t;

	typedef struct packed {
		logic valid;
		rlmc_cmd_kind_t kind;
		logic [1:0] arg;
	} rlmc_cmd_t;

	typedef struct packed {
		logic remoteLocalButton;
		logic settingHold;
		logic previewButton;
		logic limitPreviewButton;
		logic voltStep;
		logic voltUp;
		logic currStep;
		logic currUp;
	} rlmc_panel_t;

	typedef struct packed {
		rlmc_mode_t mode;
		logic [4:0] unitAddr;
		logic [2:0] baudSel;
		logic [4:0] pendAddr;
		logic [2:0] pendBaud;
		logic inMenu;
		logic [TIMER_W-1:0] idle;
		logic [SW_W-1:0] sw1;
		logic [SW_W-1:0] sw2;
		logic [SW_W-1:0] sw3;
		logic [SW_W-1:0] swF;
		logic [2:0] sel;
		logic selF;
		logic voltWrite;
		logic currWrite;
		logic otherWrite;
		logic previewShow;
		logic limitShow;
		logic panelAdjust;
		logic analogVolt;
		logic analogCurr;
		logic analogAny;
		logic resistive;
		logic [31:0] rdata;
	} rlmc_state_t;
endpackage : rlmc_pkg

// ==== rtl/rlmc_control.sv ====
// remote/local mode control: unit address, baud selection, remote state machine,
// front-panel gating and analog/resistive setpoint lockout
// assumes decoded serial commands and panel events arrive as one-cycle pulses on clock
//
// Contract
// - unit address 0..30 stored as bus identity
// - five baud rates 1200..19200, exactly one selected
// - reset gives address 6, 9600 baud, RS-232, panel unlocked, output off
// - switch six down selects RS-232, up selects RS-485
// - remote entered only by reset, voltage, current, output or remote-mode commands
// - remote returns local by button or mode command 0; argument 1 selects remote
// - argument 2 latches lockout; button ignored; leaves only on argument 1 or power cycle; code also leaves lockout for remote on a safe-reset command
// - in local a query stays local; output-affecting commands execute then go remote
// - remote disables panel except preview, limit preview and remote/local button
// - lockout keeps only preview and limit preview active
// - address adjust commits and leaves display after 3 s without movement
// - baud adjust saves last rate and reverts after 3 s without movement
// - resistive programming needs switches seven, eight, voltage and current select up
// - resistive mode ignores voltage and current setpoints from panel and serial
// - analog mode still accepts all other parameters over the serial port
// - select switches down ignore select pin; up, low pin selects analog remote
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rlmc_control #(
	parameter int unsigned HOLD_CYCLES = rlmc_pkg::SETTLE_CYCLES
) (
	input wire logic clock, // 200 MHz
	input wire logic reset, // asynchronous, high; also the AC power cycle
	input wire rlmc_pkg::rlmc_cmd_t cmd, // decoded serial command pulse
	input wire rlmc_pkg::rlmc_panel_t panel, // front-panel event pulses
	input wire logic [rlmc_pkg::SW_W-1:0] setupSwitchBank, // pins, 1 = up
	input wire logic remoteSelectPin, // analog remote/local select pin
	input wire logic [7:0] regAddr, // register byte address
	input wire logic [31:0] regWdata, // write data
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	output logic [31:0] regRdata, // read data, cycle after the read strobe
	output rlmc_pkg::rlmc_mode_t mode, // local, remote or lockout
	output logic [4:0] unitAddr, // committed unit address
	output logic [2:0] baudSel, // committed baud code
	output logic portIsRs485, // physical port type
	output logic settingDisplay, // address/baud shown on meters
	output logic [4:0] shownAddr, // address on the voltage meter
	output logic [2:0] shownBaud, // baud code on the current meter
	output logic panelAdjust, // encoders and buttons active
	output logic previewShow, // setpoint preview pulse
	output logic limitShow, // limit preview pulse
	output logic voltWrite, // accepted voltage setpoint change pulse
	output logic currWrite, // accepted current setpoint change pulse
	output logic otherWrite, // accepted other-parameter command pulse
	output logic analogRemote, // analog remote indication
	output logic resistive // resistive programming active
);
	localparam logic [rlmc_pkg::TIMER_W-1:0] HOLD_LAST =
		rlmc_pkg::TIMER_W'(HOLD_CYCLES - 1);

	rlmc_pkg::rlmc_state_t st;
	rlmc_pkg::rlmc_state_t next_st;

	function automatic logic [4:0] stepAddr(input logic [4:0] a, input logic up);
		if (up) begin
			stepAddr = (a >= rlmc_pkg::ADDR_MAX) ? rlmc_pkg::ADDR_MAX : a + 5'h01;
		end else begin
			stepAddr = (a == 5'h00) ? 5'h00 : a - 5'h01;
		end
	endfunction : stepAddr

	function automatic logic [2:0] stepBaud(input logic [2:0] b, input logic up);
		if (up) begin
			stepBaud = (b >= rlmc_pkg::BAUD_MAX) ? rlmc_pkg::BAUD_MAX : b + 3'h1;
		end else begin
			stepBaud = (b == 3'h0) ? 3'h0 : b - 3'h1;
		end
	endfunction : stepBaud

	function automatic logic affectsOutput(input rlmc_pkg::rlmc_cmd_kind_t k);
		affectsOutput = (k == rlmc_pkg::CMD_SAFE_RESET) || (k == rlmc_pkg::CMD_OUTPUT) ||
			(k == rlmc_pkg::CMD_VOLTAGE_PROGRAM) || (k == rlmc_pkg::CMD_CURRENT_PROGRAM) ||
			(k == rlmc_pkg::CMD_REMOTE_MODE);
	endfunction : affectsOutput

	always_comb begin
		logic aV;
		logic aC;
		logic res;
		logic moved;
		logic isLocal;
		aV = 1'b0;
		aC = 1'b0;
		res = 1'b0;
		moved = 1'b0;
		isLocal = 1'b0;
		next_st = st;
		// pin inputs: three stages, accepted once stages two and three agree
		next_st.sw1 = setupSwitchBank;
		next_st.sw2 = st.sw1;
		next_st.sw3 = st.sw2;
		if (st.sw2 == st.sw3) begin
			next_st.swF = st.sw3;
		end
		next_st.sel = {st.sel[1:0], remoteSelectPin};
		if (st.sel[1] == st.sel[2]) begin
			next_st.selF = st.sel[2];
		end
		// low or shorted select pin means analog remote, only with its switch up
		aV = st.swF[rlmc_pkg::SW_VOLT_REMOTE] & ~st.selF;
		aC = st.swF[rlmc_pkg::SW_CURR_REMOTE] & ~st.selF;
		res = aV & aC & st.swF[rlmc_pkg::SW_RESIST_A] & st.swF[rlmc_pkg::SW_RESIST_B];
		next_st.analogVolt = aV;
		next_st.analogCurr = aC;
		next_st.analogAny = aV | aC;
		next_st.resistive = res;
		next_st.voltWrite = 1'b0;
		next_st.currWrite = 1'b0;
		next_st.otherWrite = 1'b0;
		isLocal = (st.mode == rlmc_pkg::MODE_LOCAL);
		// serial commands take priority over the panel button in the same cycle
		if (cmd.valid) begin
			// setpoints are refused while analog or resistive control owns them
			next_st.voltWrite = (cmd.kind == rlmc_pkg::CMD_VOLTAGE_PROGRAM) & ~aV;
			next_st.currWrite = (cmd.kind == rlmc_pkg::CMD_CURRENT_PROGRAM) & ~aC;
			next_st.otherWrite = (cmd.kind == rlmc_pkg::CMD_OTHER_SETTING) ||
				(cmd.kind == rlmc_pkg::CMD_OUTPUT) ||
				(cmd.kind == rlmc_pkg::CMD_SAFE_RESET);
			if (cmd.kind == rlmc_pkg::CMD_REMOTE_MODE) begin
				case (cmd.arg)
					2'h0: begin
						if (st.mode != rlmc_pkg::MODE_LOCKOUT) begin
							next_st.mode = rlmc_pkg::MODE_LOCAL;
						end
					end
					2'h1: next_st.mode = rlmc_pkg::MODE_REMOTE;
					2'h2: next_st.mode = rlmc_pkg::MODE_LOCKOUT;
					default: next_st.mode = st.mode;
				endcase
			end else if (cmd.kind == rlmc_pkg::CMD_SAFE_RESET) begin
				next_st.mode = rlmc_pkg::MODE_REMOTE; // non-lockout remote
			end else if (isLocal && affectsOutput(cmd.kind)) begin
				next_st.mode = rlmc_pkg::MODE_REMOTE;
			end
		end else if (panel.remoteLocalButton && st.mode == rlmc_pkg::MODE_REMOTE) begin
			next_st.mode = rlmc_pkg::MODE_LOCAL; // button ignored in lockout
		end
		// address/baud setting display, reachable from local only
		if (!st.inMenu) begin
			next_st.idle = '0;
			if (isLocal && panel.settingHold) begin
				next_st.inMenu = 1'b1;
				next_st.pendAddr = st.unitAddr;
				next_st.pendBaud = st.baudSel;
			end else if (isLocal && !res) begin
				next_st.voltWrite = next_st.voltWrite | (panel.voltStep & ~aV);
				next_st.currWrite = next_st.currWrite | (panel.currStep & ~aC);
			end
		end else begin
			moved = panel.voltStep | panel.currStep;
			if (panel.voltStep) begin
				next_st.pendAddr = stepAddr(st.pendAddr, panel.voltUp);
			end
			if (panel.currStep) begin
				next_st.pendBaud = stepBaud(st.pendBaud, panel.currUp);
			end
			if (moved) begin
				next_st.idle = '0;
			end else if (st.idle == HOLD_LAST) begin
				next_st.inMenu = 1'b0;
				next_st.unitAddr = st.pendAddr;
				next_st.baudSel = st.pendBaud;
			end else begin
				next_st.idle = st.idle + 1'b1;
			end
		end
		// leaving local abandons an uncommitted entry
		if (next_st.mode != rlmc_pkg::MODE_LOCAL) begin
			next_st.inMenu = 1'b0;
		end
		// preview buttons stay live in every mode
		next_st.previewShow = panel.previewButton;
		next_st.limitShow = panel.limitPreviewButton;
		next_st.panelAdjust = (next_st.mode == rlmc_pkg::MODE_LOCAL);
		// software may set address and baud; out-of-range values are ignored
		if (regWrite && regAddr == rlmc_pkg::REG_CONFIG) begin
			if (regWdata[rlmc_pkg::CFG_ADDR_LSB +: 5] <= rlmc_pkg::ADDR_MAX) begin
				next_st.unitAddr = regWdata[rlmc_pkg::CFG_ADDR_LSB +: 5];
			end
			if (regWdata[rlmc_pkg::CFG_BAUD_LSB +: 3] <= rlmc_pkg::BAUD_MAX) begin
				next_st.baudSel = regWdata[rlmc_pkg::CFG_BAUD_LSB +: 3];
			end
		end
		next_st.rdata = '0;
		if (regRead) begin
			case (regAddr)
				rlmc_pkg::REG_CONFIG: begin
					next_st.rdata[rlmc_pkg::CFG_ADDR_LSB +: 5] = st.unitAddr;
					next_st.rdata[rlmc_pkg::CFG_BAUD_LSB +: 3] = st.baudSel;
				end
				rlmc_pkg::REG_STATUS: begin
					next_st.rdata[rlmc_pkg::ST_MODE_LSB +: 3] = st.mode;
					next_st.rdata[rlmc_pkg::ST_RS485_BIT] = st.swF[rlmc_pkg::SW_PORT_TYPE];
					next_st.rdata[rlmc_pkg::ST_AVOLT_BIT] = st.analogVolt;
					next_st.rdata[rlmc_pkg::ST_ACURR_BIT] = st.analogCurr;
					next_st.rdata[rlmc_pkg::ST_RESIST_BIT] = st.resistive;
					next_st.rdata[rlmc_pkg::ST_MENU_BIT] = st.inMenu;
				end
				default: next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.mode <= rlmc_pkg::MODE_LOCAL;
			st.unitAddr <= rlmc_pkg::ADDR_RESET;
			st.baudSel <= rlmc_pkg::BAUD_RESET;
			st.pendAddr <= rlmc_pkg::ADDR_RESET;
			st.pendBaud <= rlmc_pkg::BAUD_RESET;
			st.panelAdjust <= 1'b1;
			st.selF <= 1'b1;
			st.sel <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	assign regRdata = st.rdata;
	assign mode = st.mode;
	assign unitAddr = st.unitAddr;
	assign baudSel = st.baudSel;
	assign portIsRs485 = st.swF[rlmc_pkg::SW_PORT_TYPE];
	assign settingDisplay = st.inMenu;
	assign shownAddr = st.pendAddr;
	assign shownBaud = st.pendBaud;
	assign panelAdjust = st.panelAdjust;
	assign previewShow = st.previewShow;
	assign limitShow = st.limitShow;
	assign voltWrite = st.voltWrite;
	assign currWrite = st.currWrite;
	assign otherWrite = st.otherWrite;
	assign analogRemote = st.analogAny;
	assign resistive = st.resistive;

	a_lockout_button_ignored: assert property (@(posedge clock) disable iff (reset)
		st.mode == rlmc_pkg::MODE_LOCKOUT && !cmd.valid |=> st.mode == rlmc_pkg::MODE_LOCKOUT)
		else $error("lockout left without a mode command");
	a_query_stays_local: assert property (@(posedge clock) disable iff (reset)
		st.mode == rlmc_pkg::MODE_LOCAL && cmd.valid && cmd.kind == rlmc_pkg::CMD_QUERY
		|=> st.mode == rlmc_pkg::MODE_LOCAL)
		else $error("query moved unit out of local");
	a_command_goes_remote: assert property (@(posedge clock) disable iff (reset)
		st.mode == rlmc_pkg::MODE_LOCAL && cmd.valid &&
		(cmd.kind == rlmc_pkg::CMD_OUTPUT || cmd.kind == rlmc_pkg::CMD_VOLTAGE_PROGRAM)
		|=> st.mode == rlmc_pkg::MODE_REMOTE)
		else $error("output command did not select remote");
	a_local_needs_serial: assert property (@(posedge clock) disable iff (reset)
		st.mode == rlmc_pkg::MODE_LOCAL && !cmd.valid |=> st.mode == rlmc_pkg::MODE_LOCAL)
		else $error("remote entered without serial command");
	a_address_range: assert property (@(posedge clock) disable iff (reset)
		st.unitAddr <= rlmc_pkg::ADDR_MAX && st.pendAddr <= rlmc_pkg::ADDR_MAX)
		else $error("address outside 0 to 30");
	a_baud_range: assert property (@(posedge clock) disable iff (reset)
		st.baudSel <= rlmc_pkg::BAUD_MAX)
		else $error("baud code outside five rates");
	a_resistive_blocks_set: assert property (@(posedge clock) disable iff (reset)
		st.resistive && st.analogVolt == next_st.analogVolt &&
		st.analogCurr == next_st.analogCurr |=> !st.voltWrite && !st.currWrite)
		else $error("setpoint accepted in resistive mode");
	a_idle_commit: assert property (@(posedge clock) disable iff (reset)
		st.inMenu && st.idle == HOLD_LAST && !panel.voltStep && !panel.currStep &&
		!cmd.valid && !regWrite
		|=> !st.inMenu && st.unitAddr == $past(st.pendAddr) && st.baudSel == $past(st.pendBaud))
		else $error("setting not committed after idle time");
	a_remote_panel_off: assert property (@(posedge clock) disable iff (reset)
		st.mode != rlmc_pkg::MODE_LOCAL |-> !st.inMenu && !st.panelAdjust)
		else $error("panel adjust live outside local");
	a_select_switch_down: assert property (@(posedge clock) disable iff (reset)
		!st.swF[rlmc_pkg::SW_VOLT_REMOTE] && !st.swF[rlmc_pkg::SW_CURR_REMOTE]
		|=> !st.analogVolt && !st.analogCurr)
		else $error("analog remote with select switches down");
	a_button_to_local: assert property (@(posedge clock) disable iff (reset)
		st.mode == rlmc_pkg::MODE_REMOTE && !cmd.valid && panel.remoteLocalButton
		|=> st.mode == rlmc_pkg::MODE_LOCAL)
		else $error("remote/local button did not return to local");
	a_mode_arg_one: assert property (@(posedge clock) disable iff (reset)
		cmd.valid && cmd.kind == rlmc_pkg::CMD_REMOTE_MODE && cmd.arg == 2'h1
		|=> st.mode == rlmc_pkg::MODE_REMOTE)
		else $error("mode command one did not select remote");
	a_mode_arg_two: assert property (@(posedge clock) disable iff (reset)
		cmd.valid && cmd.kind == rlmc_pkg::CMD_REMOTE_MODE && cmd.arg == 2'h2
		|=> st.mode == rlmc_pkg::MODE_LOCKOUT)
		else $error("mode command two did not latch lockout");
	a_remote_arg_zero: assert property (@(posedge clock) disable iff (reset)
		st.mode == rlmc_pkg::MODE_REMOTE && cmd.valid &&
		cmd.kind == rlmc_pkg::CMD_REMOTE_MODE && cmd.arg == 2'h0 |=> st.mode == rlmc_pkg::MODE_LOCAL)
		else $error("mode command zero did not return to local");
	a_preview_live: assert property (@(posedge clock) disable iff (reset)
		panel.previewButton |=> st.previewShow)
		else $error("setpoint preview button ignored");
	a_limit_preview_live: assert property (@(posedge clock) disable iff (reset)
		panel.limitPreviewButton |=> st.limitShow)
		else $error("limit preview button ignored");
	a_other_accepted: assert property (@(posedge clock) disable iff (reset)
		cmd.valid && cmd.kind == rlmc_pkg::CMD_OTHER_SETTING |=> st.otherWrite)
		else $error("other parameter command refused");
	a_port_type_follows: assert property (@(posedge clock) disable iff (reset)
		st.sw2[rlmc_pkg::SW_PORT_TYPE] == st.sw3[rlmc_pkg::SW_PORT_TYPE]
		|=> portIsRs485 == $past(st.sw3[rlmc_pkg::SW_PORT_TYPE]))
		else $error("port type does not follow switch six");
	a_analog_volt_refused: assert property (@(posedge clock) disable iff (reset)
		cmd.valid && cmd.kind == rlmc_pkg::CMD_VOLTAGE_PROGRAM &&
		st.swF[rlmc_pkg::SW_VOLT_REMOTE] && !st.selF |=> !st.voltWrite)
		else $error("voltage setpoint accepted under analog control");
endmodule : rlmc_control
`default_nettype wire

// ==== tb/rlmc_host_model.sv ====
// host controller model: issues decoded serial commands toward the block
// assumes the bench asks for one command at a time, just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rlmc_host_model (
	input wire logic clock, // bench clock
	input wire logic reset, // asynchronous, high
	input wire logic sendReq, // one-cycle request from the bench
	input wire rlmc_pkg::rlmc_cmd_t sendCmd, // command to issue
	output rlmc_pkg::rlmc_cmd_t cmd // toward the block
);
	// one unit with one address on the chain, so no address clash
	// that unit is first in the chain, so either port type is allowed
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cmd <= '0;
		end else if (sendReq) begin
			cmd <= sendCmd;
		end else begin
			// idle fields toggle so a stale kind or argument is never reused
			cmd.valid <= 1'b0;
			cmd.kind <= rlmc_pkg::rlmc_cmd_kind_t'(~cmd.kind);
			cmd.arg <= ~cmd.arg;
		end
	end
endmodule : rlmc_host_model
`default_nettype wire

// ==== tb/rlmc_control_tb.sv ====
// testbench for the remote/local mode control block
// assumes a short settle count so the setting display commits quickly
`timescale 1ns/1ps
`default_nettype none
module rlmc_control_tb;
	localparam int HOLD = 20;
	localparam logic [31:0] mLoc = 32'h1;
	localparam logic [31:0] mRem = 32'h2;
	localparam logic [31:0] mLock = 32'h4;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic sendReq = 1'b0;
	rlmc_pkg::rlmc_cmd_t sendCmd = '0;
	rlmc_pkg::rlmc_cmd_t cmd;
	rlmc_pkg::rlmc_panel_t panel = '0;
	logic [8:0] sw = '0;
	logic selPin = 1'b1;
	logic [7:0] regAddr = '0;
	logic [31:0] regWdata = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdata, rd;
	rlmc_pkg::rlmc_mode_t mode;
	logic [4:0] unitAddr, shownAddr;
	logic [2:0] baudSel, shownBaud;
	logic portIsRs485, settingDisplay, panelAdjust, previewShow, voltWrite, currWrite;
	logic otherWrite, analogRemote, resistive, limitShow;
	int badCount = 0;
	int nTests = 0;
	int nVolt = 0;
	int nCurr = 0;
	int nOther = 0;
	int nPrev = 0;
	int cycles = 0;
	int v0;
	int o0;
	int c0;
	int nLim = 0;
	rlmc_host_model i_host (.clock(clock), .reset(reset), .sendReq(sendReq), .sendCmd(sendCmd),
		.cmd(cmd));
	rlmc_control #(.HOLD_CYCLES(HOLD)) i_dut (.clock(clock), .reset(reset), .cmd(cmd),
		.panel(panel), .setupSwitchBank(sw), .remoteSelectPin(selPin), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.mode(mode), .unitAddr(unitAddr), .baudSel(baudSel), .portIsRs485(portIsRs485),
		.settingDisplay(settingDisplay), .shownAddr(shownAddr), .shownBaud(shownBaud),
		.panelAdjust(panelAdjust), .previewShow(previewShow), .limitShow(limitShow),
		.voltWrite(voltWrite), .currWrite(currWrite), .otherWrite(otherWrite),
		.analogRemote(analogRemote), .resistive(resistive));
	initial begin
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		nVolt <= nVolt + int'(voltWrite === 1'b1);
		nCurr <= nCurr + int'(currWrite === 1'b1);
		nOther <= nOther + int'(otherWrite === 1'b1);
		nPrev <= nPrev + int'(previewShow === 1'b1);
		nLim <= nLim + int'(limitShow === 1'b1);
		if (cycles == 20000) begin
			badCount++;
			endOfTest();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			badCount++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wcyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wcyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		rd = regRdata;
	endtask : rdr
	task automatic send(input rlmc_pkg::rlmc_cmd_kind_t k, input logic [1:0] a);
		@(posedge clock);
		sendReq <= 1'b1;
		sendCmd <= {1'b1, k, a};
		@(posedge clock);
		sendReq <= 1'b0;
		wcyc(3);
	endtask : send
	task automatic press(input int b, input logic up);
		rlmc_pkg::rlmc_panel_t p;
		p = '0;
		p[b] = 1'b1;
		p.voltUp = up;
		p.currUp = up;
		@(posedge clock);
		panel <= p;
		@(posedge clock);
		panel <= '0;
		wcyc(2);
	endtask : press
	task automatic endOfTest();
		$display("compares %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : endOfTest
	initial begin
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		wcyc(2);
		chk(32'(mode), mLoc);
		chk({unitAddr, baudSel, portIsRs485, panelAdjust}, {5'h06, 3'h3, 1'b0, 1'b1});
		rdr(rlmc_pkg::REG_STATUS);
		chk(rd, 32'h1);
		$display("reset values done");
		v0 = nVolt;
		press(3, 1'b1);
		press(5, 1'b1);
		chk(nVolt - v0, 1);
		// address up past the top, baud down past the bottom
		press(6, 1'b0);
		chk(32'(settingDisplay), 1);
		for (int i = 0; i < 28; i++) press(3, 1'b1);
		for (int i = 0; i < 5; i++) press(1, 1'b0);
		chk({shownAddr, unitAddr}, {5'h1e, 5'h06});
		chk(32'(shownBaud), 32'h0);
		chk(nVolt - v0, 1);
		wcyc(HOLD + 6);
		chk({unitAddr, baudSel, settingDisplay}, {5'h1e, 3'h0, 1'b0});
		$display("setting display done");
		wr(rlmc_pkg::REG_CONFIG, 32'h0405);
		wr(rlmc_pkg::REG_CONFIG, 32'h021f);
		rdr(rlmc_pkg::REG_CONFIG);
		chk(rd, 32'h0205);
		wcyc(1);
		chk(regRdata, 32'h0);
		wr(rlmc_pkg::REG_CONFIG, 32'h071e);
		rdr(rlmc_pkg::REG_CONFIG);
		chk(rd, 32'h021e);
		rdr(8'h08);
		chk(rd, 32'h0);
		$display("registers done");
		send(rlmc_pkg::CMD_QUERY, 2'h0);
		chk(32'(mode), mLoc);
		for (int k = 1; k <= 4; k++) begin
			send(rlmc_pkg::rlmc_cmd_kind_t'(k), 2'h1);
			chk(32'(mode), mRem);
			press(7, 1'b0);
			chk(32'(mode), mLoc);
		end
		send(rlmc_pkg::CMD_REMOTE_MODE, 2'h1);
		chk({29'h0, mode}, mRem);
		v0 = nVolt;
		press(3, 1'b1);
		press(5, 1'b1);
		chk(nVolt - v0, 0);
		chk(32'(panelAdjust), 0);
		chk(nPrev, 2);
		send(rlmc_pkg::CMD_REMOTE_MODE, 2'h2);
		chk(32'(mode), mLock);
		press(7, 1'b0);
		press(5, 1'b0);
		press(4, 1'b0);
		chk(32'(mode), mLock);
		chk(nPrev, 3);
		chk(nLim, 1);
		send(rlmc_pkg::CMD_REMOTE_MODE, 2'h0);
		chk(32'(mode), mLock);
		send(rlmc_pkg::CMD_REMOTE_MODE, 2'h3);
		chk(32'(mode), mLock);
		send(rlmc_pkg::CMD_REMOTE_MODE, 2'h1);
		chk(32'(mode), mRem);
		send(rlmc_pkg::CMD_REMOTE_MODE, 2'h0);
		chk(32'(mode), mLoc);
		send(rlmc_pkg::CMD_REMOTE_MODE, 2'h2);
		chk(32'(mode), mLock);
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		wcyc(2);
		chk(32'(mode), mLoc);
		$display("mode machine done");
		@(posedge clock);
		sw <= 9'h020;
		wcyc(8);
		chk(32'(portIsRs485), 1);
		@(posedge clock);
		sw <= 9'h003;
		wcyc(8);
		chk(32'(analogRemote), 0);
		@(posedge clock);
		selPin <= 1'b0;
		wcyc(8);
		chk(32'(analogRemote), 1);
		v0 = nVolt;
		o0 = nOther;
		send(rlmc_pkg::CMD_VOLTAGE_PROGRAM, 2'h0);
		send(rlmc_pkg::CMD_OTHER_SETTING, 2'h0);
		chk(nVolt - v0, 0);
		chk(nOther - o0, 1);
		@(posedge clock);
		sw <= 9'h0c3;
		wcyc(8);
		chk(32'(resistive), 1);
		rdr(rlmc_pkg::REG_STATUS);
		chk(rd, 32'h000000e2);
		c0 = nCurr;
		send(rlmc_pkg::CMD_CURRENT_PROGRAM, 2'h0);
		chk(nCurr - c0, 0);
		@(posedge clock);
		selPin <= 1'b1;
		wcyc(8);
		chk({analogRemote, resistive}, 2'b00);
		$display("switches done");
		endOfTest();
	end
endmodule : rlmc_control_tb
`default_nettype wire
